// *** logic/cdma_consts.svh ***
// Constants shared by both ends of the display memory address path.
// Assumes it is included by bare name after the package is compiled.
`ifndef CDMA_CONSTS_SVH
`define CDMA_CONSTS_SVH
`define CDMA_AW            14
`define CDMA_DW            8
`define CDMA_PTR_W         5
`define CDMA_PTR_MODE      5'h08
`define CDMA_PTR_UPD_HI    5'h12
`define CDMA_PTR_UPD_LO    5'h13
`define CDMA_PTR_DUMMY     5'h1f
`define CDMA_MODE_RESET    8'h00
`define CDMA_MODE_TRANSP   3
`define CDMA_MODE_BLANK    6
`define CDMA_MODE_DE_SKEW  4
`define CDMA_MODE_CUR_SKEW 5
`define CDMA_STAT_READY    7
`define CDMA_STAT_VRETRACE 5
`define CDMA_PHI_HALF      2'h2
`define CDMA_LAST_STEP     2'h2
`endif

// *** logic/cdma_pkg.sv ***
// Types shared by both ends of the display memory address path.
// Assumes nothing beyond the constants header.
`default_nettype none
package cdma_pkg;
   typedef logic [13:0] cdma_addr_t;
   typedef logic [7:0]  cdma_byte_t;
   typedef enum logic [1:0] {
      CDMA_SCH_PRIO  = 2'h0,
      CDMA_SCH_INTLV = 2'h1,
      CDMA_SCH_VBLNK = 2'h2
   } cdma_scheme_t;
   typedef enum logic [3:0] {
      CDMA_H_IDLE = 4'h1,
      CDMA_H_WAIT = 4'h2,
      CDMA_H_BUS  = 4'h4,
      CDMA_H_UPD  = 4'h8
   } cdma_hstate_t;
endpackage
`default_nettype wire

// *** logic/cdma_if.sv ***
// Link between the controller and the host contention logic.
// Assumes both ends run on the same clock; every signal is a plain level.
`timescale 1ns/10ps
`default_nettype none
interface cdma_if;
   import cdma_pkg::*;
   logic       reg_cs;      // Register access this cycle.
   logic       reg_rs;      // Low selects pointer, high the pointed register.
   logic       reg_we;      // High writes, low reads.
   cdma_byte_t reg_wdata;   // Write data.
   cdma_byte_t reg_rdata;   // Status byte, always valid.
   logic       phi2;        // Second bus clock phase.
   cdma_addr_t ma;          // Display memory address lines.
   logic       upd_strobe;  // Update address is on the address lines.
   modport dev  (input reg_cs, reg_rs, reg_we, reg_wdata, phi2,
                 output reg_rdata, ma, upd_strobe);
   modport host (output reg_cs, reg_rs, reg_we, reg_wdata, phi2,
                 input reg_rdata, ma, upd_strobe);
endinterface
`default_nettype wire

// *** logic/cdma_skew.sv ***
// Optional one character period delay for display enable and cursor.
// Assumes the tick input pulses once per character period on CLK.
`timescale 1ns/10ps
`default_nettype none
module cdma_skew (
   input  wire logic       clk,   // System clock.
   input  wire logic       rst,   // Asynchronous reset, high.
   input  wire logic       tick,  // Character period pulse.
   input  wire logic [1:0] sig,   // Undelayed signals.
   input  wire logic [1:0] skew,  // Per signal delay enable.
   output logic      [1:0] q      // Registered result.
);
   import cdma_pkg::*;
   logic [1:0] hold_r;
   logic [1:0] hold_nxt;
   logic [1:0] q_nxt;
   genvar g;
   // Each channel keeps the value seen at the last tick, one period old.
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         always_comb begin
            hold_nxt[g] = tick ? sig[g] : hold_r[g];
            q_nxt[g]    = skew[g] ? hold_r[g] : sig[g];
         end
      end
   endgenerate
   // Both paths see one clock of register latency so skew is pure period delay.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_r <= 2'h0;
         q      <= 2'h0;
      end else begin
         hold_r <= hold_nxt;
         q      <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// *** logic/cdma_ctrl.sv ***
// Controller end: register port, refresh scan, update address engine.
// Assumes the timing chain drives blanking, enable and cursor on CLK.
`timescale 1ns/10ps
`default_nettype none
`include "cdma_consts.svh"
module cdma_ctrl (
   input  wire logic         CLK,       // System clock, 25 MHz.
   input  wire logic         RST,       // Asynchronous reset, high.
   cdma_if.dev               bus,       // Host register port and memory lines.
   input  wire logic         CHAR_TICK, // One pulse per character.
   input  wire logic         HBLANK,    // Horizontal blanking.
   input  wire logic         VBLANK,    // Vertical blanking.
   input  wire logic         DE_IN,     // Undelayed display enable.
   input  wire logic         CURSOR_IN, // Undelayed cursor.
   output logic              DISP_EN,   // Display enable, maybe skewed.
   output logic              CURSOR,    // Cursor, maybe skewed.
   output logic              STB,       // Update strobe pin function.
   output cdma_pkg::cdma_byte_t MODE    // Mode control register.
);
   import cdma_pkg::*;
   logic [`CDMA_PTR_W-1:0] ptr_r;
   logic [`CDMA_PTR_W-1:0] ptr_nxt;
   cdma_byte_t mode_r;
   cdma_byte_t mode_nxt;
   cdma_addr_t upd_r;
   cdma_addr_t upd_nxt;
   cdma_addr_t scan_r;
   cdma_addr_t scan_nxt;
   cdma_addr_t ma_r;
   cdma_addr_t ma_nxt;
   logic       pend_r;
   logic       pend_nxt;
   logic       ready_r;
   logic       ready_nxt;
   logic       stb_r;
   logic       stb_nxt;
   logic       vret_r;
   logic       vret_nxt;
   cdma_byte_t stat_r;
   cdma_byte_t stat_nxt;
   logic       data_acc;
   logic       transp;
   logic       blank_md;
   logic       window;
   logic       do_upd;

   // Decode a data cycle aimed at one register number.
   function automatic logic hit(input logic acc, input logic [`CDMA_PTR_W-1:0] p,
                                input logic [`CDMA_PTR_W-1:0] want);
      return acc && (p == want);
   endfunction

   assign data_acc = bus.reg_cs && bus.reg_rs;
   assign transp   = mode_r[`CDMA_MODE_TRANSP];
   assign blank_md = mode_r[`CDMA_MODE_BLANK];

   // Update window: second phase when interleaving, blanking otherwise.
   always_comb begin
      if (blank_md) begin
         window = HBLANK || VBLANK;
      end else begin
         window = bus.phi2;
      end
      do_upd = transp && pend_r && window;
   end

   // Register port. Only the pointer, mode and update pair store data.
   always_comb begin
      ptr_nxt  = ptr_r;
      mode_nxt = mode_r;
      upd_nxt  = upd_r;
      if (bus.reg_cs && !bus.reg_rs && bus.reg_we) begin
         ptr_nxt = bus.reg_wdata[`CDMA_PTR_W-1:0];
      end
      if (hit(data_acc && bus.reg_we, ptr_r, `CDMA_PTR_MODE)) begin
         mode_nxt = bus.reg_wdata;
      end
      if (do_upd) begin
         upd_nxt = upd_r + 14'h0001;
      end else if (hit(data_acc && bus.reg_we, ptr_r, `CDMA_PTR_UPD_HI)) begin
         upd_nxt = {bus.reg_wdata[5:0], upd_r[7:0]};
      end else if (hit(data_acc && bus.reg_we, ptr_r, `CDMA_PTR_UPD_LO)) begin
         upd_nxt = {upd_r[13:8], bus.reg_wdata};
      end
   end

   // Any read or write of the dummy location asks for one update.
   // A completed update sets ready; a new request clears it, but the set wins.
   always_comb begin
      pend_nxt  = pend_r;
      ready_nxt = ready_r;
      if (hit(data_acc, ptr_r, `CDMA_PTR_DUMMY)) begin
         pend_nxt  = 1'b1;
         ready_nxt = 1'b0;
      end else if (do_upd) begin
         pend_nxt = 1'b0;
      end
      if (do_upd) begin
         ready_nxt = 1'b1;
      end
   end

   // Refresh scan advances per character and restarts in vertical blanking.
   always_comb begin
      if (VBLANK) begin
         scan_nxt = 14'h0000;
      end else if (CHAR_TICK) begin
         scan_nxt = scan_r + 14'h0001;
      end else begin
         scan_nxt = scan_r;
      end
   end

   // Address lines. In transparent mode the host never reaches memory
   // directly, so every address it uses leaves here.
   always_comb begin
      ma_nxt  = scan_r;
      stb_nxt = 1'b0;
      if (transp) begin
         if (do_upd) begin
            ma_nxt  = upd_r;
            stb_nxt = 1'b1;
         end else if (!blank_md && bus.phi2) begin
            ma_nxt = upd_r;
         end
      end
   end

   // Status byte: update ready and vertical retrace.
   always_comb begin
      vret_nxt                      = VBLANK;
      stat_nxt                      = 8'h00;
      stat_nxt[`CDMA_STAT_READY]    = ready_r;
      stat_nxt[`CDMA_STAT_VRETRACE] = vret_r;
   end

   // Register port state. Mode resets to shared addressing so the host owns nothing yet.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ptr_r  <= 5'h00;
         mode_r <= `CDMA_MODE_RESET;
         upd_r  <= 14'h0000;
      end else begin
         ptr_r  <= ptr_nxt;
         mode_r <= mode_nxt;
         upd_r  <= upd_nxt;
      end
   end

   // Update engine flags.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pend_r  <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         pend_r  <= pend_nxt;
         ready_r <= ready_nxt;
      end
   end

   // Refresh scan counter.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         scan_r <= 14'h0000;
      end else begin
         scan_r <= scan_nxt;
      end
   end

   // Address lines and strobe leave from flops, so memory never sees decode glitches.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ma_r  <= 14'h0000;
         stb_r <= 1'b0;
      end else begin
         ma_r  <= ma_nxt;
         stb_r <= stb_nxt;
      end
   end

   // Status byte. Retrace passes two flops, so the host sees it two cycles late.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         vret_r <= 1'b0;
         stat_r <= 8'h00;
      end else begin
         vret_r <= vret_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign bus.ma         = ma_r;
   assign bus.upd_strobe = stb_r;
   assign bus.reg_rdata  = stat_r;
   assign STB            = stb_r;
   assign MODE           = mode_r;

   // Skew of display enable and cursor, one character period each.
   cdma_skew u_skew (
      .clk  (CLK),
      .rst  (RST),
      .tick (CHAR_TICK),
      .sig  ({CURSOR_IN, DE_IN}),
      .skew ({mode_r[`CDMA_MODE_CUR_SKEW], mode_r[`CDMA_MODE_DE_SKEW]}),
      .q    ({CURSOR, DISP_EN})
   );
endmodule
`default_nettype wire

// *** logic/cdma_host.sv ***
// Host end: bus phase generator, register writes and memory contention.
// Assumes one request at a time, pulsed for one cycle while BUSY is low.
`timescale 1ns/10ps
`default_nettype none
`include "cdma_consts.svh"
module cdma_host (
   input  wire logic               CLK,         // System clock, 25 MHz.
   input  wire logic               RST,         // Asynchronous reset, high.
   cdma_if.host                    bus,         // Controller link.
   input  wire logic               MODE_LOAD,   // Pulse: write MODE_BITS.
   input  wire cdma_pkg::cdma_byte_t MODE_BITS, // Mode control value.
   input  wire logic               TRANSPARENT, // Access via controller.
   input  wire cdma_pkg::cdma_scheme_t SCHEME,  // Shared mode scheme.
   input  wire logic               REQ,         // Pulse: memory access.
   input  wire logic               WE,          // Access is a write.
   input  wire cdma_pkg::cdma_addr_t ADDR,      // Access address.
   input  wire cdma_pkg::cdma_byte_t WDATA,     // Access write data.
   output logic                    BUSY,        // Request in progress.
   output cdma_pkg::cdma_addr_t    MEM_ADDR,    // Memory address.
   output logic                    MEM_WE,      // Memory write strobe.
   output cdma_pkg::cdma_byte_t    MEM_WDATA    // Memory write data.
);
   import cdma_pkg::*;
   cdma_hstate_t st_r, st_nxt;
   logic [1:0] cnt_r, cnt_nxt, step_r, step_nxt;
   logic       phi_r, phi_nxt, half_r, half_nxt, ldm_r, ldm_nxt, we_r, we_nxt;
   logic       busy_nxt, mwe_nxt, cs_nxt, rs_nxt;
   cdma_addr_t addr_r, addr_nxt, maddr_nxt;
   cdma_byte_t dat_r, dat_nxt, mode_r, mode_nxt, wd_nxt, wd_r;
   cdma_scheme_t sch_r, sch_nxt;
   logic       grant;

   // Register number and data for one step of a write sequence.
   function automatic cdma_byte_t step_word(input logic ptr, input logic ldm,
                                            input logic [1:0] s, input cdma_addr_t a,
                                            input cdma_byte_t m);
      if (ldm) return ptr ? {3'h0, `CDMA_PTR_MODE} : m;
      case (s)
         2'h0:    return ptr ? {3'h0, `CDMA_PTR_UPD_HI} : {2'h0, a[13:8]};
         2'h1:    return ptr ? {3'h0, `CDMA_PTR_UPD_LO} : a[7:0];
         default: return ptr ? {3'h0, `CDMA_PTR_DUMMY} : 8'h00;
      endcase
   endfunction

   // Phase generator and access window.
   always_comb begin
      cnt_nxt = (cnt_r == `CDMA_PHI_HALF - 2'h1) ? 2'h0 : cnt_r + 2'h1;
      phi_nxt = (cnt_r == `CDMA_PHI_HALF - 2'h1) ? !phi_r : phi_r;
      case (sch_r)
         CDMA_SCH_INTLV: grant = phi_r;
         CDMA_SCH_VBLNK: grant = bus.reg_rdata[`CDMA_STAT_VRETRACE];
         default:        grant = 1'b1;
      endcase
   end

   // Sequencer.
   always_comb begin
      st_nxt   = st_r;
      step_nxt = step_r;
      half_nxt = half_r;
      ldm_nxt  = ldm_r;
      addr_nxt = addr_r;
      dat_nxt  = dat_r;
      we_nxt   = we_r;
      mode_nxt = mode_r;
      sch_nxt  = sch_r;
      cs_nxt   = 1'b0;
      rs_nxt   = 1'b0;
      mwe_nxt  = 1'b0;
      wd_nxt = step_word(!half_r, ldm_r, step_r, addr_r, mode_r);
      case (st_r)
         CDMA_H_IDLE: begin
            step_nxt = 2'h0;
            half_nxt = 1'b0;
            if (MODE_LOAD) begin
               mode_nxt = MODE_BITS;
               ldm_nxt  = 1'b1;
               st_nxt   = CDMA_H_BUS;
            end else if (REQ) begin
               addr_nxt = ADDR;
               we_nxt   = WE;
               sch_nxt  = SCHEME;
               ldm_nxt  = 1'b0;
               dat_nxt  = WDATA;
               st_nxt   = TRANSPARENT ? CDMA_H_BUS : CDMA_H_WAIT;
            end
         end
         CDMA_H_WAIT: begin
            if (grant) begin
               mwe_nxt = we_r;
               st_nxt  = CDMA_H_IDLE;
            end
         end
         CDMA_H_BUS: begin
            cs_nxt   = 1'b1;
            rs_nxt   = half_r;
            half_nxt = !half_r;
            if (half_r) begin
               step_nxt = step_r + 2'h1;
               if (ldm_r) st_nxt = CDMA_H_IDLE;
               else if (step_r == `CDMA_LAST_STEP) st_nxt = CDMA_H_UPD;
            end
         end
         CDMA_H_UPD: begin
            if (bus.upd_strobe) begin
               mwe_nxt = we_r;
               st_nxt  = CDMA_H_IDLE;
            end
         end
         default: st_nxt = CDMA_H_IDLE;
      endcase
      // Shared mode address mux; transparent mode only passes the lines through.
      if (!TRANSPARENT && ((st_r == CDMA_H_WAIT && grant) ||
                           (SCHEME == CDMA_SCH_INTLV && phi_r))) begin
         maddr_nxt = addr_r;
      end else begin
         maddr_nxt = bus.ma;
      end
      busy_nxt = (st_nxt != CDMA_H_IDLE);
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_r       <= CDMA_H_IDLE;
         cnt_r      <= 2'h0;
         phi_r      <= 1'b0;
         step_r     <= 2'h0;
         half_r     <= 1'b0;
         ldm_r      <= 1'b0;
         we_r       <= 1'b0;
         addr_r     <= 14'h0000;
         dat_r      <= 8'h00;
         mode_r     <= 8'h00;
         sch_r      <= CDMA_SCH_PRIO;
         BUSY       <= 1'b0;
         MEM_ADDR   <= 14'h0000;
         MEM_WE     <= 1'b0;
         MEM_WDATA  <= 8'h00;
         bus.reg_cs <= 1'b0;
         bus.reg_rs <= 1'b0;
         wd_r       <= 8'h00;
      end else begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         phi_r      <= phi_nxt;
         step_r     <= step_nxt;
         half_r     <= half_nxt;
         ldm_r      <= ldm_nxt;
         we_r       <= we_nxt;
         addr_r     <= addr_nxt;
         dat_r      <= dat_nxt;
         mode_r     <= mode_nxt;
         sch_r      <= sch_nxt;
         BUSY       <= busy_nxt;
         MEM_ADDR   <= maddr_nxt;
         MEM_WE     <= mwe_nxt;
         MEM_WDATA  <= dat_r;
         bus.reg_cs <= cs_nxt;
         bus.reg_rs <= rs_nxt;
         wd_r       <= wd_nxt;
      end
   end

   assign bus.reg_we    = 1'b1;
   assign bus.reg_wdata = wd_r;
   assign bus.phi2      = phi_r;
endmodule
`default_nettype wire

// *** bench/cdma_chk_sva.sv ***
// Checker for the link between the controller and the host ends.
// Assumes the bench instantiates it beside the link, fed with the link signals.
`timescale 1ns/10ps
`default_nettype none
`include "cdma_consts.svh"
module cdma_chk (
   input wire logic                 CLK,        // System clock.
   input wire logic                 RST,        // Asynchronous reset, high.
   input wire logic                 reg_cs,     // Register cycle.
   input wire logic                 reg_rs,     // Pointer or data.
   input wire logic                 reg_we,     // Write strobe.
   input wire cdma_pkg::cdma_byte_t reg_wdata,  // Write data.
   input wire cdma_pkg::cdma_byte_t reg_rdata,  // Status byte.
   input wire logic                 phi2,       // Second bus phase.
   input wire cdma_pkg::cdma_addr_t ma,         // Address lines.
   input wire logic                 upd_strobe  // Update strobe.
);
   import cdma_pkg::*;
   logic [4:0] ptr_r, ptr_nxt;
   cdma_byte_t mode_r, mode_nxt;
   cdma_addr_t upd_r, upd_nxt;
   logic       wr_dat;
   // Mirror pointer, mode and update address from the writes seen on the link.
   assign wr_dat = reg_cs && reg_rs && reg_we;
   always_comb begin
      ptr_nxt = ptr_r;
      mode_nxt = mode_r;
      upd_nxt = upd_r;
      if (reg_cs && !reg_rs) ptr_nxt = reg_wdata[4:0];
      if (wr_dat && ptr_r == `CDMA_PTR_MODE) mode_nxt = reg_wdata;
      if (wr_dat && ptr_r == `CDMA_PTR_UPD_HI) upd_nxt[13:8] = reg_wdata[5:0];
      if (wr_dat && ptr_r == `CDMA_PTR_UPD_LO) upd_nxt[7:0] = reg_wdata;
      if (upd_strobe) upd_nxt = upd_r + 14'h0001;
   end
   // The mirror only needs to be right after the host has loaded it.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ptr_r <= 5'h00;
         mode_r <= `CDMA_MODE_RESET;
         upd_r <= 14'h0000;
      end else begin
         ptr_r <= ptr_nxt;
         mode_r <= mode_nxt;
         upd_r <= upd_nxt;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   property p_phi2_shape;
      $rose(phi2) |=> phi2 ##1 !phi2 [*2] ##1 phi2;
   endproperty
   a_phi2_shape: assert property (p_phi2_shape) else $error("phase shape wrong");
   property p_stb_pulse;
      upd_strobe |=> !upd_strobe;
   endproperty
   a_stb_pulse: assert property (p_stb_pulse) else $error("strobe longer than one cycle");
   property p_stb_transp;
      upd_strobe |-> mode_r[`CDMA_MODE_TRANSP];
   endproperty
   a_stb_transp: assert property (p_stb_transp) else $error("strobe outside transparent mode");
   property p_stb_phase;
      upd_strobe && !mode_r[`CDMA_MODE_BLANK] |-> $past(phi2) || $past(phi2, 2);
   endproperty
   a_stb_phase: assert property (p_stb_phase) else $error("update outside second phase");
   property p_stb_addr;
      upd_strobe |-> ma == upd_r;
   endproperty
   a_stb_addr: assert property (p_stb_addr) else $error("update address wrong");
   property p_ready_set;
      upd_strobe |-> ##[0:1] reg_rdata[`CDMA_STAT_READY];
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready bit not set");
   property p_ready_clr;
      reg_cs && reg_rs && ptr_r == `CDMA_PTR_DUMMY |=> ##1 (!reg_rdata[`CDMA_STAT_READY] || upd_strobe);
   endproperty
   a_ready_clr: assert property (p_ready_clr) else $error("ready bit not cleared");
   property p_data_after_ptr;
      reg_cs && reg_rs |-> $past(reg_cs) && !$past(reg_rs);
   endproperty
   a_data_after_ptr: assert property (p_data_after_ptr) else $error("data without pointer");
endmodule
`default_nettype wire

// *** bench/test_crt_display_memory_addressing.sv ***
// Self-checking bench joining the controller and host ends over the link.
// Assumes the design files and the constants header are on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "cdma_consts.svh"
module test_crt_display_memory_addressing;
   import cdma_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         mode_load = 1'b0;
   cdma_byte_t   mode_bits = 8'h00;
   logic         transparent = 1'b0;
   cdma_scheme_t scheme = CDMA_SCH_PRIO;
   logic         req = 1'b0;
   cdma_addr_t   addr = 14'h0000;
   cdma_byte_t   wdata = 8'h00;
   logic         char_tick = 1'b0;
   logic         hblank = 1'b0;
   logic         vblank = 1'b0;
   logic         de_in = 1'b0;
   logic         cursor_in = 1'b0;
   logic [1:0]   tick_cnt = 2'h0;
   logic         busy, mem_we, disp_en, cursor, stb, stb_seen;
   cdma_addr_t   mem_addr, stb_ma;
   cdma_byte_t   mem_wdata, mode;
   int           n_errors = 0;
   int           n_checks = 0;
   cdma_if cdma_if_i ();
   cdma_ctrl cdma_ctrl_i (.CLK(clk), .RST(rst), .bus(cdma_if_i.dev), .CHAR_TICK(char_tick), .HBLANK(hblank),
      .VBLANK(vblank), .DE_IN(de_in), .CURSOR_IN(cursor_in), .DISP_EN(disp_en), .CURSOR(cursor), .STB(stb),
      .MODE(mode));
   cdma_host cdma_host_i (.CLK(clk), .RST(rst), .bus(cdma_if_i.host), .MODE_LOAD(mode_load), .MODE_BITS(mode_bits),
      .TRANSPARENT(transparent), .SCHEME(scheme), .REQ(req), .WE(1'b1), .ADDR(addr), .WDATA(wdata),
      .BUSY(busy), .MEM_ADDR(mem_addr), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata));
   cdma_chk cdma_chk_i (.CLK(clk), .RST(rst), .reg_cs(cdma_if_i.reg_cs), .reg_rs(cdma_if_i.reg_rs),
      .reg_we(cdma_if_i.reg_we), .reg_wdata(cdma_if_i.reg_wdata), .reg_rdata(cdma_if_i.reg_rdata),
      .phi2(cdma_if_i.phi2), .ma(cdma_if_i.ma), .upd_strobe(cdma_if_i.upd_strobe));
   // Clock at 25 MHz.
   always #20 clk = ~clk;
   // Character tick every fourth clock, so skew is visible between ticks.
   always @(posedge clk) begin
      tick_cnt <= #1 tick_cnt + 2'h1;
      char_tick <= #1 (tick_cnt == 2'h3);
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic set_mode(input cdma_byte_t m);
      mode_load = 1'b1;
      mode_bits = m;
      transparent = m[`CDMA_MODE_TRANSP];
      cyc(1);
      mode_load = 1'b0;
      cyc(4);
      chk(mode, m);
   endtask
   task automatic start(input cdma_addr_t a);
      req = 1'b1;
      addr = a;
      wdata = a[7:0];
      cyc(1);
      req = 1'b0;
   endtask
   // Bounded wait for the memory write, noting any update strobe on the way.
   task automatic wait_we(input cdma_addr_t a);
      int i;
      stb_seen = 1'b0;
      for (i = 0; i < 200 && mem_we !== 1'b1; i++) begin
         cyc(1);
         if (cdma_if_i.upd_strobe === 1'b1) begin
            stb_seen = 1'b1;
            stb_ma = cdma_if_i.ma;
            chk(stb, 1'b1);
         end
      end
      chk(mem_we, 1'b1);
      chk(mem_addr, a);
      chk(mem_wdata, a[7:0]);
      if (mem_we !== 1'b1) summarize();
      cyc(2);
   endtask
   // Nothing may reach memory while the access window is shut.
   task automatic hold_off;
      repeat (20) begin
         cyc(1);
         chk({cdma_if_i.upd_strobe, mem_we}, 2'b00);
      end
   endtask
   task automatic t_shared;
      set_mode(8'h00);
      start(14'h0123);
      wait_we(14'h0123);
      chk(stb_seen, 1'b0);
      scheme = CDMA_SCH_INTLV;
      start(14'h2abc);
      wait_we(14'h2abc);
      scheme = CDMA_SCH_VBLNK;
      start(14'h0777);
      hold_off();
      vblank = 1'b1;
      wait_we(14'h0777);
      chk(cdma_if_i.reg_rdata[`CDMA_STAT_VRETRACE], 1'b1);
      vblank = 1'b0;
   endtask
   task automatic t_transp;
      int i;
      set_mode(8'h08);
      start(14'h1234);
      wait_we(14'h1234);
      chk({stb_seen, stb_ma}, {1'b1, 14'h1234});
      for (i = 0; i < 8 && cdma_if_i.ma !== 14'h1235; i++) cyc(1);
      chk(cdma_if_i.ma, 14'h1235);
      set_mode(8'h48);
      start(14'h3fff);
      hold_off();
      hblank = 1'b1;
      wait_we(14'h3fff);
      chk({stb_seen, stb_ma}, {1'b1, 14'h3fff});
      chk(cdma_if_i.reg_rdata[`CDMA_STAT_READY], 1'b1);
      hblank = 1'b0;
   endtask
   // Skewed outputs hold the value of the previous tick for a full character.
   task automatic t_skew;
      int i;
      set_mode(8'h30);
      for (i = 0; i < 8 && char_tick !== 1'b1; i++) cyc(1);
      cyc(1);
      de_in = 1'b1;
      cursor_in = 1'b1;
      cyc(3);
      chk({disp_en, cursor}, 2'b00);
      cyc(1);
      chk({disp_en, cursor}, 2'b11);
      de_in = 1'b0;
      cursor_in = 1'b0;
      set_mode(8'h00);
      de_in = 1'b1;
      cyc(2);
      chk({disp_en, cursor}, 2'b10);
   endtask
   // Main sequence: reset, then each scenario in turn.
   initial begin
      cyc(5);
      rst = 1'b0;
      cyc(1);
      chk({busy, mem_we, stb, mode}, 14'h0000);
      t_shared();
      t_transp();
      t_skew();
      summarize();
   end
endmodule
`default_nettype wire
